// ---- hdl/lcdp_pkg.sv ----
// Package of constants, types and helpers for the LED channel duty PWM block
package lcdp_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int          NUM_CH       = 9;
  localparam int          CODE_W       = 8;
  localparam int          IDX_W        = 4;
  localparam logic [7:0]  PWM_LAST     = 8'hFE;  // 255 steps: 0..254
  localparam int          PRESCALE_DEF = 16;
  localparam logic [7:0]  CODE_OFF     = 8'h00;
  localparam logic [7:0]  CODE_FULL    = 8'hFF;
  localparam logic [7:0]  DUTY_RESET   = 8'h00;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  CH1_DUTY_OFS = 8'h16;
  localparam logic [7:0]  CH2_DUTY_OFS = 8'h17;
  localparam logic [7:0]  CH3_DUTY_OFS = 8'h18;
  localparam logic [7:0]  CH4_DUTY_OFS = 8'h19;
  localparam logic [7:0]  CH5_DUTY_OFS = 8'h1A;
  localparam logic [7:0]  CH6_DUTY_OFS = 8'h1B;
  localparam logic [7:0]  CH7_DUTY_OFS = 8'h1C;
  localparam logic [7:0]  CH8_DUTY_OFS = 8'h1D;
  localparam logic [7:0]  CH9_DUTY_OFS = 8'h1E;
  localparam logic [7:0]  DUTY_FIRST   = CH1_DUTY_OFS;
  localparam logic [7:0]  DUTY_LAST    = CH9_DUTY_OFS;
  localparam logic [7:0]  CTRL_FIRST   = 8'h06;
  localparam logic [7:0]  CTRL_LAST    = 8'h0E;
  localparam int          CURVE_BIT    = 5;
  localparam logic        CURVE_RESET  = 1'b0;

  // ************************************************************
  // Serial port
  // ************************************************************
  localparam logic [6:0]  DEV_ADDR_DEF = 7'h2A;  // Arbitrary value
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [1:0]  LOAD_DLY     = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WRITE = 3'b011,
    ST_ACK   = 3'b100,
    ST_READ  = 3'b101,
    ST_RACK  = 3'b110
  } lcdp_state_t;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic in_duty(input logic [7:0] a);
    return (a >= DUTY_FIRST) && (a <= DUTY_LAST);
  endfunction

  function automatic logic in_ctrl(input logic [7:0] a);
    return (a >= CTRL_FIRST) && (a <= CTRL_LAST);
  endfunction

  // Pointer holds still across the duty range
  function automatic logic [7:0] next_ptr(input logic [7:0] a);
    return in_duty(a) ? a : 8'(a + 8'h01);
  endfunction

  // Exponential curve; end codes kept so 0 stays off and FF stays on
  function automatic logic [7:0] log_curve(input logic [7:0] c);
    logic [12:0] v;
    v = 13'({1'b1, c[4:0]}) << c[7:5];
    if (c == CODE_OFF || c == CODE_FULL) begin
      return c;
    end
    return v[12:5];
  endfunction

endpackage

// ---- hdl/lcdp_duty_mem.sv ----
// Duty code storage for all channels with registered read port
`timescale 1ns/1ps
module lcdp_duty_mem
  import lcdp_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  wr_en,
  input  wire logic [IDX_W-1:0]      wr_idx,
  input  wire logic [CODE_W-1:0]     wr_data,
  input  wire logic [IDX_W-1:0]      rd_idx,
  output logic      [CODE_W-1:0]     rd_data_q,
  output logic      [N*CODE_W-1:0]   duty_flat
);

  logic [CODE_W-1:0] mem_q [N];

  if (N < 1 || N > (1 << IDX_W)) begin : g_chk
    $error("lcdp_duty_mem: channel count out of range");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= DUTY_RESET;  // [RULE_03]
      end
    end else if (wr_en && (int'(wr_idx) < N)) begin
      mem_q[wr_idx] <= wr_data;  // [RULE_04]
    end
  end

  // Read returns last written code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= DUTY_RESET;
    end else if (int'(rd_idx) < N) begin
      rd_data_q <= mem_q[rd_idx];  // [RULE_04]
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      duty_flat[i*CODE_W +: CODE_W] = mem_q[i];
    end
  end

endmodule

// ---- hdl/lcdp_pwm_core.sv ----
// Free-running period counter and per-channel duty compare
`timescale 1ns/1ps
module lcdp_pwm_core
  import lcdp_pkg::*;
#(
  parameter int N        = NUM_CH,
  parameter int PRESCALE = PRESCALE_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [N*CODE_W-1:0]   duty_flat,
  input  wire logic [N-1:0]          curve_sel,
  input  wire logic [N-1:0]          engine_sel,
  input  wire logic [N*CODE_W-1:0]   engine_duty,
  output logic      [N-1:0]          led_on_q
);

  localparam int PS_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  if (PRESCALE < 1 || N < 1) begin : g_chk
    $error("lcdp_pwm_core: bad prescale or channel count");
  end

  logic [PS_W-1:0] ps_q;
  logic            tick;
  logic [7:0]      cnt_q;
  logic [7:0]      code [N];

  assign tick = (ps_q == PS_W'(PRESCALE - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_q <= '0;
    end else if (tick) begin
      ps_q <= '0;
    end else begin
      ps_q <= PS_W'(ps_q + 1'b1);
    end
  end

  // Counter wraps at 254 so code FF is on all period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (tick) begin
      cnt_q <= (cnt_q == PWM_LAST) ? 8'h00 : 8'(cnt_q + 8'h01);  // [RULE_12] [RULE_02]
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      // Duty register only counts under direct control
      code[i] = engine_sel[i] ? engine_duty[i*CODE_W +: CODE_W]
                              : duty_flat[i*CODE_W +: CODE_W];  // [RULE_05] [RULE_06]
      if (curve_sel[i]) begin
        code[i] = log_curve(code[i]);  // [RULE_11]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_on_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        led_on_q[i] <= (cnt_q < code[i]);  // [RULE_12] [RULE_01] [RULE_02]
      end
    end
  end

endmodule

// ---- hdl/lcdp_top.sv ----
// Serial register port, control bits and channel PWM of the LED duty block
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - Each channel has 8-bit duty; 00 always off, FF always on.
// RULE_02 - On-time grows linearly, one 255th of period per code step.
// RULE_03 - All duty registers reset to zero.
// RULE_04 - Host can write and read back every duty register.
// RULE_05 - Duty registers drive outputs only in direct control, not engine control.
// RULE_06 - Direct control is the default after power-up.
// RULE_07 - Register pointer does not auto-advance within 0x16 to 0x1E.
// RULE_08 - Host keeps duty at half scale when temperature compensation is on.
// RULE_09 - Channels one to seven duty at consecutive addresses 0x16 to 0x1C.
// RULE_10 - Channels eight and nine duty at 0x1D and 0x1E.
// RULE_11 - Per-channel curve bit picks linear or logarithmic mapping in all modes.
// RULE_12 - Free-running 255-step counter; output on while counter below code.
module lcdp_top
  import lcdp_pkg::*;
#(
  parameter int         N        = NUM_CH,
  parameter int         PRESCALE = PRESCALE_DEF,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  input  wire logic [N-1:0]          engine_sel,
  input  wire logic [N*CODE_W-1:0]   engine_duty,
  output logic      [N-1:0]          led_on
);

  if (N != NUM_CH) begin : g_chk
    $error("lcdp_top: register map serves exactly nine channels");
  end

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ************************************************************
  // Line sampling and bus conditions
  // ************************************************************
  logic scl_q;
  logic sda_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_q      <= scl_i;
      sda_q      <= sda_i;
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise  = scl_q & ~scl_prev_q;
  assign scl_fall  = ~scl_q & scl_prev_q;
  assign bus_start = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign bus_stop  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

  // ************************************************************
  // Transfer state
  // ************************************************************
  lcdp_state_t state_q;
  lcdp_state_t next_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic [2:0]  bit_q;
  logic [2:0]  tx_bit_q;
  logic        full_q;
  logic        rnw_q;
  logic        mack_q;
  logic [1:0]  load_q;
  logic [7:0]  ptr_q;
  logic        wr_pulse;
  logic [7:0]  rd_value;
  logic [7:0]  mem_rd;
  logic        addr_hit;

  assign addr_hit = (rx_q[7:1] == DEV_ADDR);
  assign wr_pulse = (state_q == ST_WRITE) && scl_fall && full_q;

  // Receive shifter; full_q marks the eighth bit seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q   <= 8'h00;
      bit_q  <= 3'h0;
      full_q <= 1'b0;
    end else if (bus_start) begin
      bit_q  <= 3'h0;
      full_q <= 1'b0;
    end else if (scl_rise && (state_q == ST_ADDR || state_q == ST_PTR ||
                              state_q == ST_WRITE)) begin
      rx_q   <= {rx_q[6:0], sda_q};
      bit_q  <= 3'(bit_q + 3'h1);
      full_q <= (bit_q == BIT_LAST);
    end else if (scl_fall && full_q) begin
      full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      next_q  <= ST_IDLE;
      rnw_q   <= 1'b0;
      mack_q  <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_ADDR;
      mack_q  <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_fall && full_q) begin
            rnw_q   <= rx_q[0];
            next_q  <= rx_q[0] ? ST_READ : ST_PTR;
            state_q <= addr_hit ? ST_ACK : ST_IDLE;
          end
        end
        ST_PTR: begin
          if (scl_fall && full_q) begin
            next_q  <= ST_WRITE;
            state_q <= ST_ACK;
          end
        end
        ST_WRITE: begin
          if (scl_fall && full_q) begin
            next_q  <= ST_WRITE;
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_q <= next_q;
          end
        end
        ST_READ: begin
          if (scl_fall && tx_bit_q == BIT_LAST && load_q == 2'h0) begin
            state_q <= ST_RACK;
            mack_q  <= 1'b0;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_q;
          end
          if (scl_rise && sda_q) begin
            state_q <= ST_IDLE;  // Master NACK ends the read
          end else if (scl_fall && mack_q) begin
            state_q <= ST_READ;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Register pointer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
    end else if (state_q == ST_PTR && scl_fall && full_q) begin
      ptr_q <= rx_q;
    end else if (wr_pulse || (state_q == ST_RACK && scl_fall && mack_q)) begin
      ptr_q <= next_ptr(ptr_q);  // [RULE_07]
    end
  end

  // ************************************************************
  // Control bits: curve select in bit 5 of each channel control
  // ************************************************************
  logic [N-1:0] curve_q;
  logic [7:0]   ctrl_idx;
  logic [7:0]   duty_idx;

  assign ctrl_idx = 8'(ptr_q - CTRL_FIRST);
  assign duty_idx = 8'(ptr_q - DUTY_FIRST);  // [RULE_09] [RULE_10]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      curve_q <= {N{CURVE_RESET}};
    end else if (wr_pulse && in_ctrl(ptr_q)) begin
      curve_q[ctrl_idx[IDX_W-1:0]] <= rx_q[CURVE_BIT];  // [RULE_11]
    end
  end

  // Unused control bits read zero
  always_comb begin
    rd_value = 8'h00;
    if (in_duty(ptr_q)) begin
      rd_value = mem_rd;  // [RULE_04]
    end else if (in_ctrl(ptr_q)) begin
      rd_value[CURVE_BIT] = curve_q[ctrl_idx[IDX_W-1:0]];
    end
  end

  // ************************************************************
  // Transmit path and line drive
  // ************************************************************
  // Two-cycle wait lets the registered read catch a moved pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 2'h0;
    end else if ((state_q == ST_ACK && next_q == ST_READ && scl_fall) ||
                 (state_q == ST_RACK && scl_fall && mack_q)) begin
      load_q <= LOAD_DLY;
    end else if (load_q != 2'h0) begin
      load_q <= 2'(load_q - 2'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
    end else if (state_q == ST_READ && load_q == 2'h1) begin
      tx_q <= rd_value;
    end else if (state_q == ST_READ && scl_fall && load_q == 2'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Receive count sits idle while sending, so the read byte needs its own
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_q <= 3'h0;
    end else if (state_q == ST_READ && load_q == 2'h1) begin
      tx_bit_q <= 3'h0;
    end else if (state_q == ST_READ && scl_fall && load_q == 2'h0) begin
      tx_bit_q <= 3'(tx_bit_q + 3'h1);
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe <= 1'b0;
    end else if (scl_fall && full_q && (state_q == ST_PTR || state_q == ST_WRITE ||
                                        (state_q == ST_ADDR && addr_hit))) begin
      sda_oe <= 1'b1;
    end else if (state_q == ST_ACK && scl_fall) begin
      sda_oe <= 1'b0;
    end else if (state_q == ST_READ && load_q == 2'h1) begin
      sda_oe <= ~rd_value[7];
    end else if (state_q == ST_READ && scl_fall && load_q == 2'h0) begin
      sda_oe <= (tx_bit_q == BIT_LAST) ? 1'b0 : ~tx_q[6];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ************************************************************
  // Duty storage and PWM
  // ************************************************************
  logic [N*CODE_W-1:0] duty_flat;

  lcdp_duty_mem #(
    .N (N)
  ) u_mem (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_pulse && in_duty(ptr_q)),
    .wr_idx    (duty_idx[IDX_W-1:0]),
    .wr_data   (rx_q),
    .rd_idx    (duty_idx[IDX_W-1:0]),
    .rd_data_q (mem_rd),
    .duty_flat (duty_flat)
  );

  lcdp_pwm_core #(
    .N        (N),
    .PRESCALE (PRESCALE)
  ) u_pwm (
    .clk         (clk),
    .rst_n       (rst_n),
    .duty_flat   (duty_flat),
    .curve_sel   (curve_q),
    .engine_sel  (engine_sel),
    .engine_duty (engine_duty),
    .led_on_q    (led_on)
  );

endmodule

// ---- tb/lcdp_top_props.sv ----
// Port assertions for the LED duty PWM block
`timescale 1ns/1ps
module lcdp_top_props
  import lcdp_pkg::*;
#(
  parameter int         N        = NUM_CH,
  parameter int         PRESCALE = PRESCALE_DEF,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                scl_i,
  input wire logic                sda_i,
  input wire logic                sda_o,
  input wire logic                sda_oe,
  input wire logic [N-1:0]        engine_sel,
  input wire logic [N*CODE_W-1:0] engine_duty,
  input wire logic [N-1:0]        led_on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  int on_run;
  int off_run;
  int on_last;
  int stab;
  // ****
  // Pulse bookkeeping on channel one
  // ****
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      on_run  <= 0;
      off_run <= 0;
      on_last <= 0;
    end else if (led_on[0]) begin
      on_run  <= on_run + 1;
      off_run <= 0;
    end else begin
      on_run  <= 0;
      off_run <= off_run + 1;
      on_last <= (on_run != 0) ? on_run : on_last;
    end
  end
  // Period sums only mean something once the code sat still
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stab <= 0;
    end else if (!engine_sel[0] || $changed(engine_duty[7:0])) begin
      stab <= 0;
    end else if (stab < 3 * 255 * PRESCALE) begin
      stab <= stab + 1;
    end
  end
  for (genvar i = 0; i < N; i++) begin : g_ch
    chk_code_off: assert property (
      (engine_sel[i] && engine_duty[i*CODE_W+:CODE_W] == CODE_OFF)[*5] |-> !led_on[i])
      else $error("Code zero left an output on");
    chk_code_full: assert property (
      (engine_sel[i] && engine_duty[i*CODE_W+:CODE_W] == CODE_FULL)[*5] |-> led_on[i])
      else $error("Full code left an output off");
  end
  chk_reset_dark: assert property (
    $rose(resetn) && engine_sel == '0 |-> (led_on == '0)[*3])
    else $error("Output on straight after reset");
  chk_idle_quiet: assert property (
    $rose(resetn) |-> (!sda_oe)[*4])
    else $error("Data line pulled after reset");
  chk_oe_low_scl: assert property (
    $changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("Data drive moved while clock high");
  chk_ack_hold: assert property (
    $rose(sda_oe) |-> sda_oe[*5])
    else $error("Data drive too short");
  chk_sda_low: assert property (
    sda_oe |-> sda_o == 1'b0)
    else $error("Data line driven high");
  chk_pwm_period: assert property (
    $rose(led_on[0]) && stab > 2 * 255 * PRESCALE |-> off_run + on_last == 255 * PRESCALE)
    else $error("PWM period length wrong");
  cov_ack: cover property ($rose(sda_oe));
  cov_period: cover property ($rose(led_on[0]) && stab > 2 * 255 * PRESCALE);
  cov_engine: cover property (engine_sel[0] && led_on[0]);
endmodule

bind lcdp_top lcdp_top_props #(
  .N(N), .PRESCALE(PRESCALE), .DEV_ADDR(DEV_ADDR)
) u_lcdp_top_props (
  .clk(clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .engine_sel(engine_sel), .engine_duty(engine_duty), .led_on(led_on)
);

// ---- tb/lcdp_host.sv ----
// Serial bus host model that reads and writes the duty block
`timescale 1ns/1ps
module lcdp_host
  import lcdp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  logic [6:0] addr_v = DEV_ADDR;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // ****
  // Bus phases, every move just after a clock edge
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // High releases the line to its pull-up
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_w;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic start();
    sda_m = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_m = 1'b0;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_m = 1'b1;
    tick(8);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic nack, output logic [7:0] r,
                        output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(nack, b);
    ack = !b;
  endtask
  // Each duty register gets an addressed access of its own
  task automatic open_ptr(input logic [7:0] ptr, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    start();
    byte_x({addr_v, 1'b0}, 1'b1, r, a0);
    byte_x(ptr, 1'b1, r, a1);
    ok = a0 && a1;
  endtask
  // Temperature compensation stays off, so full-scale codes are fair
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a;
    open_ptr(ptr, ok);
    byte_x(d, 1'b1, r, a);
    ok = ok && a;
    stop();
  endtask
  task automatic wr2(input logic [7:0] ptr, input logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    open_ptr(ptr, ok);
    byte_x(d[15:8], 1'b1, r, a0);
    byte_x(d[7:0], 1'b1, r, a1);
    ok = ok && a0 && a1;
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a;
    open_ptr(ptr, ok);
    start();
    byte_x({addr_v, 1'b1}, 1'b1, r, a);
    byte_x(8'hFF, 1'b1, d, r[0]);
    ok = ok && a;
    stop();
  endtask
endmodule

// ---- tb/lcdp_top_test.sv ----
// Self-checking bench for the LED duty PWM block
`timescale 1ns/1ps
module lcdp_top_test
  import lcdp_pkg::*;
;
  localparam int PS  = 2;
  localparam int PER = 255 * PS;
  logic                     clk;
  logic                     resetn;
  logic                     scl;
  logic                     sda_m;
  logic                     sda_o;
  logic                     sda_oe;
  logic [NUM_CH-1:0]        engine_sel;
  logic [NUM_CH*CODE_W-1:0] engine_duty;
  logic [NUM_CH-1:0]        led_on;
  logic [7:0]               shadow [NUM_CH];
  logic [7:0]               rv;
  logic                     ok;
  int                       n_errors;
  int                       cmp_count;
  int                       chs [6] = '{0, 8, 4, 2, 6, 1};
  logic [7:0]               codes [6] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'hFE, 8'hFF};
  logic [7:0]               eng [3] = '{8'h03, 8'h00, 8'hFF};
  wire logic                sda_w;
  // Open drain with pull-up
  assign sda_w = sda_m & ~(sda_oe & ~sda_o);
  initial clk = 1'b0;
  always #25 clk = ~clk;
  lcdp_top #(.N(NUM_CH), .PRESCALE(PS), .DEV_ADDR(DEV_ADDR_DEF)) u_lcdp_top (
    .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .engine_sel(engine_sel), .engine_duty(engine_duty), .led_on(led_on));
  lcdp_host #(.DEV_ADDR(DEV_ADDR_DEF)) u_lcdp_host (
    .clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  // ****
  // Checking and access helpers
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr_duty(input int ch, input logic [7:0] v);
    u_lcdp_host.wr(8'(CH1_DUTY_OFS + ch), v, ok);
    check("write ack", 16'(ok), 16'h0001);
    shadow[ch] = v;
  endtask
  task automatic rd_all();
    for (int i = 0; i < NUM_CH; i++) begin
      u_lcdp_host.rd(8'(CH1_DUTY_OFS + i), rv, ok);
      check("duty read", 16'(rv), 16'(shadow[i]));
    end
  endtask
  // Any window of one whole period holds exactly the on-time
  // Code given is the one after any curve mapping
  task automatic pwm_chk(input int ch, input logic [7:0] c);
    int cnt;
    int want;
    want = int'(c) * PS;
    cnt  = 0;
    u_lcdp_host.tick(2 * PER);
    repeat (PER) begin
      u_lcdp_host.tick(1);
      cnt += int'(led_on[ch] === 1'b1);
    end
    check("on cycles", 16'(cnt), 16'(want));
  endtask
  initial begin
    #(50 * 90000);
    n_errors++;
    $display("MISMATCH run time expected finished seen hung");
    tally_and_finish();
  end
  initial begin
    resetn      = 1'b0;
    engine_sel  = '0;
    engine_duty = '0;
    n_errors    = 0;
    cmp_count   = 0;
    foreach (shadow[i]) shadow[i] = DUTY_RESET;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    u_lcdp_host.tick(8);
    check("led reset", 16'(led_on), 16'h0000);
    rd_all();
    $display("Test reset done");
    for (int i = 0; i < NUM_CH; i++) begin
      wr_duty(i, 8'(8'hA0 + i));
    end
    rd_all();
    u_lcdp_host.wr(8'h40, 8'h5A, ok);
    u_lcdp_host.rd(8'h40, rv, ok);
    check("unmapped read", 16'(rv), 16'h0000);
    $display("Test map done");
    u_lcdp_host.wr2(CH3_DUTY_OFS, 16'h3CC3, ok);
    shadow[2] = 8'hC3;
    check("burst ack", 16'(ok), 16'h0001);
    rd_all();
    $display("Test pointer hold done");
    for (int k = 0; k < 6; k++) begin
      wr_duty(chs[k], codes[k]);
      pwm_chk(chs[k], codes[k]);
    end
    $display("Test duty done");
    wr_duty(0, 8'h80);
    engine_sel[0] = 1'b1;
    for (int k = 0; k < 3; k++) begin
      engine_duty[7:0] = eng[k];
      pwm_chk(0, eng[k]);
    end
    engine_sel[0] = 1'b0;
    pwm_chk(0, 8'h80);
    $display("Test engine done");
    u_lcdp_host.wr(CTRL_FIRST, 8'h20, ok);
    u_lcdp_host.rd(CTRL_FIRST, rv, ok);
    check("curve bit", 16'(rv), 16'h0020);
    wr_duty(0, 8'h25);
    // Log curve maps 25 to 02 and 47 to 04
    pwm_chk(0, 8'h02);
    engine_duty[7:0] = 8'h47;
    engine_sel[0]    = 1'b1;
    pwm_chk(0, 8'h04);
    engine_sel[0] = 1'b0;
    $display("Test curve done");
    u_lcdp_host.addr_v = DEV_ADDR_DEF ^ 7'h01;
    u_lcdp_host.wr(CH5_DUTY_OFS, 8'h77, ok);
    check("foreign ack", 16'(ok), 16'h0000);
    u_lcdp_host.addr_v = DEV_ADDR_DEF;
    rd_all();
    $display("Test foreign address done");
    tally_and_finish();
  end
endmodule
